// *** hdl/fbox_pkg.sv ***
// Constants, types and helpers for the 24-bit function box result section.
// Assumes a single 50 MHz clock and an AXI4-Lite master with 32-bit data.
package fbox_pkg;

  localparam int unsigned DATA_W = 24;

  // Register byte offsets
  localparam logic [7:0] OFS_X      = 8'h00;
  localparam logic [7:0] OFS_Y      = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_CFM    = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_BINARY_CONDITIONS_WORD   = 8'h14;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0018;
  localparam logic [4:0]  LEN_FULL   = 5'h18;

  localparam logic [1:0] UNIT_BIN = 2'h0;
  localparam logic [1:0] UNIT_DEC = 2'h1;

  // Carry-flag manipulate operations
  localparam logic [1:0] CFM_CLEAR  = 2'h0;
  localparam logic [1:0] CFM_SET    = 2'h1;
  localparam logic [1:0] CFM_CARRY  = 2'h2;
  localparam logic [1:0] CFM_BORROW = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [3:0] DIGIT_NINE = 4'h9;
  localparam logic [3:0] DIGIT_SIX  = 4'h6;

  typedef enum logic [3:0] {
    FN_ARITH, FN_INV_X, FN_INV_Y, FN_AND, FN_XOR, FN_OR, FN_MASK_X, FN_MASK_Y
  } func_e;

  typedef struct packed {
    logic        carry_flag_bit;
    logic [10:0] rsv_a;
    func_e       func;
    logic [3:0]  rsv_b;
    logic        sub_mode;
    logic        rsv_c;
    logic [1:0]  unit_mode;
    logic [2:0]  rsv_d;
    logic [4:0]  operand_length_field;
  } ctrl_s;

  typedef struct packed {
    logic y_low_unit_cond;
    logic carry_flag_bit;
    logic borrow_out_level;
    logic length_carry_out;
  } binary_conditions_word_s;

  // Low-order mask of the given length, all ones from 24 upward
  function automatic logic [23:0] len_mask(input logic [4:0] len);
    logic [23:0] m;
    m = 24'h000000;
    for (int i = 0; i < 24; i++) begin
      m[i] = (5'(i) < len);
    end
    return m;
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// *** hdl/fbox_results.sv ***
// Result section of the 24-bit function box behind an AXI4-Lite slave.
// Assumes one clock, synchronous active-low reset, one transfer at a time.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module fbox_results (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  // Write data channel
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // Write response channel
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  // Read address channel
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  // Read data channel
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  // Results toward the datapath
  output var  logic [23:0] main_exchange,
  output var  logic [3:0]  binary_conditions_word
);

  typedef struct packed {
    logic [23:0] res;
    logic [24:0] cv;
  } arith_s;

  logic [23:0]          x_r;
  logic [23:0]          y_r;
  fbox_pkg::ctrl_s      ctrl_r;
  logic [23:0]          result_r;
  fbox_pkg::binary_conditions_word_s      binary_conditions_word_r;
  logic                 aw_got_r;
  logic                 w_got_r;
  logic [7:0]           waddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 awready_r;
  logic                 wready_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 arready_r;
  logic                 rvalid_r;
  logic [31:0]          rdata_r;
  logic [1:0]           rresp_r;

  logic                 wr_fire;
  logic [4:0]           len;
  logic [23:0]          mask;
  logic                 dec;
  logic                 sub;
  logic                 cf;
  arith_s               ar;
  logic [23:0]          gen_t;
  logic [23:0]          prop_t;
  logic [23:0]          result_nxt;
  fbox_pkg::binary_conditions_word_s      binary_conditions_word_nxt;
  logic [24:0]          wide_sum;
  logic                 len_carry_ref;

  // Per-bit ripple adder with decimal stage correction every four bits.
  // Subtraction adds the inverted Y with the inverted carry flag as carry-in.
  function automatic arith_s arith(input logic [23:0] a,
                                   input logic [23:0] b,
                                   input logic        flag,
                                   input logic        do_sub,
                                   input logic        do_dec);
    arith_s     o;
    logic       c;
    logic       bi;
    logic       dc;
    logic [3:0] dg;
    o = '0;
    c = do_sub ? ~flag : 1'b0;
    o.cv[0] = c;
    for (int d = 0; d < 6; d++) begin
      for (int k = 0; k < 4; k++) begin
        bi = do_sub ? ~b[d*4+k] : b[d*4+k];
        dg[k] = a[d*4+k] ^ bi ^ c;
        c = (a[d*4+k] & bi) | ((a[d*4+k] ^ bi) & c);
        o.cv[d*4+k+1] = c;
      end
      if (do_dec && !do_sub) begin
        dc = c | (dg[3] & dg[1]) | (dg[3] & dg[2]);
        if (dc) begin
          dg = dg + fbox_pkg::DIGIT_SIX;
        end
        c = dc;
        o.cv[d*4+4] = c;
      end
      if (do_dec && do_sub && !c) begin
        // Borrow left as produced by the binary stage
        dg = dg - fbox_pkg::DIGIT_SIX;
      end
      o.res[d*4 +: 4] = dg;
    end
    return o;
  endfunction

  // Datapath decode
  always_comb begin
    len    = (ctrl_r.operand_length_field > fbox_pkg::LEN_FULL) ?
             fbox_pkg::LEN_FULL : ctrl_r.operand_length_field;
    mask   = fbox_pkg::len_mask(len);
    dec    = (ctrl_r.unit_mode == fbox_pkg::UNIT_DEC);
    sub    = ctrl_r.sub_mode;
    cf     = ctrl_r.carry_flag_bit;
    ar     = arith(x_r, y_r, cf, sub, dec);
    gen_t  = x_r & y_r & {24{~sub}};
    prop_t = (x_r ^ y_r) & {24{~sub}};
  end

  // Function select onto the main exchange
  always_comb begin
    case (ctrl_r.func)
      fbox_pkg::FN_ARITH:  result_nxt = ar.res & mask;
      fbox_pkg::FN_INV_X:  result_nxt = ~x_r & mask;
      fbox_pkg::FN_INV_Y:  result_nxt = ~y_r & mask;
      fbox_pkg::FN_AND:    result_nxt = gen_t & mask;
      fbox_pkg::FN_XOR:    result_nxt = prop_t & mask;
      fbox_pkg::FN_OR:     result_nxt = (x_r | y_r) & mask;
      fbox_pkg::FN_MASK_X: result_nxt = x_r & mask;
      fbox_pkg::FN_MASK_Y: result_nxt = y_r & mask;
      default:             result_nxt = 24'h000000;
    endcase
  end

  // Binary conditions
  always_comb begin
    binary_conditions_word_nxt.y_low_unit_cond = (ctrl_r.unit_mode == fbox_pkg::UNIT_BIN) ?
                               y_r[0] :
                               (y_r[3:0] == fbox_pkg::DIGIT_NINE);
    binary_conditions_word_nxt.carry_flag_bit   = cf;
    // Full width, length field plays no part
    binary_conditions_word_nxt.borrow_out_level = (x_r < y_r) || ((x_r == y_r) && cf);
    // In subtract mode the adder carry is reported as a borrow
    if (len == 5'h00) begin
      binary_conditions_word_nxt.length_carry_out = cf;
    end else begin
      binary_conditions_word_nxt.length_carry_out = ar.cv[len] ^ sub;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= 24'h000000;
      binary_conditions_word_r   <= '0;
    end else begin
      result_r <= result_nxt;
      binary_conditions_word_r   <= binary_conditions_word_nxt;
    end
  end

  // Write channel handshakes; address and data may come in either order
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      waddr_r   <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= fbox_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready_r) begin
        aw_got_r  <= 1'b1;
        waddr_r   <= awaddr;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        w_got_r  <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        case (waddr_r)
          fbox_pkg::OFS_X, fbox_pkg::OFS_Y, fbox_pkg::OFS_CTRL,
          fbox_pkg::OFS_CFM, fbox_pkg::OFS_RESULT,
          fbox_pkg::OFS_BINARY_CONDITIONS_WORD: bresp_r <= fbox_pkg::RESP_OKAY;
          default:            bresp_r <= fbox_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid_r && bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Register writes; result and conditions words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_r <= 24'h000000;
      y_r <= 24'h000000;
    end else if (wr_fire) begin
      if (waddr_r == fbox_pkg::OFS_X) begin
        x_r <= 24'(fbox_pkg::apply_strb({8'h00, x_r}, wdata_r, wstrb_r));
      end
      if (waddr_r == fbox_pkg::OFS_Y) begin
        y_r <= 24'(fbox_pkg::apply_strb({8'h00, y_r}, wdata_r, wstrb_r));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= fbox_pkg::CTRL_RESET;
    end else if (wr_fire && waddr_r == fbox_pkg::OFS_CTRL) begin
      ctrl_r <= fbox_pkg::apply_strb(ctrl_r, wdata_r, wstrb_r) &
                32'h800F_0B1F;
    end else if (wr_fire && waddr_r == fbox_pkg::OFS_CFM && wstrb_r[0]) begin
      // Software stores a detected carry or borrow for the next word pair
      case (wdata_r[1:0])
        fbox_pkg::CFM_CLEAR:  ctrl_r.carry_flag_bit <= 1'b0;
        fbox_pkg::CFM_SET:    ctrl_r.carry_flag_bit <= 1'b1;
        fbox_pkg::CFM_CARRY:  ctrl_r.carry_flag_bit <= binary_conditions_word_r.length_carry_out;
        fbox_pkg::CFM_BORROW: ctrl_r.carry_flag_bit <= binary_conditions_word_r.borrow_out_level;
        default:              ctrl_r.carry_flag_bit <= cf;
      endcase
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= fbox_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rresp_r   <= fbox_pkg::RESP_OKAY;
        case (araddr)
          fbox_pkg::OFS_X:      rdata_r <= {8'h00, x_r};
          fbox_pkg::OFS_Y:      rdata_r <= {8'h00, y_r};
          fbox_pkg::OFS_CTRL:   rdata_r <= ctrl_r;
          fbox_pkg::OFS_CFM:    rdata_r <= 32'h0000_0000;
          fbox_pkg::OFS_RESULT: rdata_r <= {8'h00, result_r};
          fbox_pkg::OFS_BINARY_CONDITIONS_WORD:   rdata_r <= {28'h0000000, binary_conditions_word_r};
          default: begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= fbox_pkg::RESP_SLVERR;
          end
        endcase
      end
      if (rvalid_r && rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign awready                = awready_r;
  assign wready                 = wready_r;
  assign bvalid                 = bvalid_r;
  assign bresp                  = bresp_r;
  assign arready                = arready_r;
  assign rvalid                 = rvalid_r;
  assign rdata                  = rdata_r;
  assign rresp                  = rresp_r;
  assign main_exchange          = result_r;
  assign binary_conditions_word = binary_conditions_word_r;

  AST_BORROW_LESS: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (x_r < y_r) |=> binary_conditions_word[1])
    else $error("borrow-out missing for X below Y");

  AST_BORROW_EQUAL: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (x_r == y_r) |=> (binary_conditions_word[1] == $past(cf)))
    else $error("borrow-out wrong for equal operands");

  AST_BORROW_FULL: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (x_r > y_r) |=> !binary_conditions_word[1])
    else $error("borrow-out set for X above Y");

  AST_LEN_ZERO_CARRY: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (len == 5'h00) |=> (binary_conditions_word[0] == $past(cf)))
    else $error("carry-out does not follow carry flag at length zero");

  AST_LOW_UNIT_BIN: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_r.unit_mode == fbox_pkg::UNIT_BIN)
      |=> (binary_conditions_word[3] == $past(y_r[0])))
    else $error("binary low-unit condition wrong");

  AST_LOW_UNIT_DEC: assert property (
    @(posedge aclk) disable iff (!aresetn)
    dec |=> (binary_conditions_word[3] == ($past(y_r[3:0]) == 4'h9)))
    else $error("decimal low-unit condition wrong");

  AST_MASK_X: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_r.func == fbox_pkg::FN_MASK_X)
      |=> (main_exchange == ($past(x_r) & $past(mask))))
    else $error("mask of X wrong");

  AST_INV_Y: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_r.func == fbox_pkg::FN_INV_Y)
      |=> (main_exchange == (~$past(y_r) & $past(mask))))
    else $error("invert of Y wrong");

  AST_AND_ADD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_r.func == fbox_pkg::FN_AND && !sub)
      |=> (main_exchange == ($past(x_r) & $past(y_r) & $past(mask))))
    else $error("AND result wrong in add mode");

  AST_CF_SET: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && waddr_r == fbox_pkg::OFS_CFM && wstrb_r[0] &&
     wdata_r[1:0] == fbox_pkg::CFM_SET) |=> ##1 binary_conditions_word[2])
    else $error("carry flag not set by manipulate command");

  AST_CF_CLEAR: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && waddr_r == fbox_pkg::OFS_CFM && wstrb_r[0] &&
     wdata_r[1:0] == fbox_pkg::CFM_CLEAR) |=> ##1 !binary_conditions_word[2])
    else $error("carry flag not cleared by manipulate command");

  AST_INV_X: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_r.func == fbox_pkg::FN_INV_X)
      |=> (main_exchange == (~$past(x_r) & $past(mask))))
    else $error("invert of X wrong");

  AST_XOR_ADD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_r.func == fbox_pkg::FN_XOR && !sub)
      |=> (main_exchange == (($past(x_r) ^ $past(y_r)) & $past(mask))))
    else $error("exclusive-OR result wrong in add mode");

  AST_OR: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_r.func == fbox_pkg::FN_OR)
      |=> (main_exchange == (($past(x_r) | $past(y_r)) & $past(mask))))
    else $error("OR result wrong");

  AST_MASK_Y: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_r.func == fbox_pkg::FN_MASK_Y)
      |=> (main_exchange == ($past(y_r) & $past(mask))))
    else $error("mask of Y wrong");

  // Plain wide sum of the masked operands, kept apart from the ripple
  // adder so the length carry is checked against a second model
  assign wide_sum      = {1'b0, x_r & mask} + {1'b0, y_r & mask};
  assign len_carry_ref = wide_sum[len];

  AST_LEN_CARRY_ADD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!sub && !dec && len != 5'h00)
      |=> (binary_conditions_word[0] == $past(len_carry_ref)))
    else $error("length carry-out wrong for binary add");

endmodule // fbox_results

`default_nettype wire

// *** sim/mex_sink.sv ***
// Datapath sink model: a destination register fed by the main exchange.
// Assumes the result section drives main_exchange as a registered level.
`timescale 1ns/10ps
`default_nettype none

module mex_sink (
  // Clock
  input  wire logic        aclk,
  // Result from the function box
  input  wire logic [23:0] main_exchange,
  input  wire logic        load,
  // Captured destination value
  output var  logic [23:0] dest
);

  // Sinks only when a micro names it as destination, so a stale
  // exchange value is never taken by accident
  always_ff @(posedge aclk) begin
    if (load) begin
      dest <= main_exchange;
    end
  end

endmodule // mex_sink

`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the function box result section.
// Assumes the AXI4-Lite timing and register map of the designer's note.
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        aclk, aresetn, load;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, binary_conditions_word;
  logic [2:0]  awprot, arprot;
  logic [1:0]  bresp, rresp, resp;
  logic [23:0] main_exchange, dest;
  int          fail_count, n_tests;

  fbox_results u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .main_exchange(main_exchange),
    .binary_conditions_word(binary_conditions_word)
  );

  mex_sink u_sink (
    .aclk(aclk), .main_exchange(main_exchange), .load(load), .dest(dest)
  );

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic end_sim;
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask

  task automatic hang;
    fail_count++;
    $display("Error at %0t: no bus answer", $time);
    end_sim;
  endtask

  // Master holds each channel until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 20) hang;
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 20) hang;
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Flags are {decimal, subtract, carry flag}
  function automatic logic [31:0] ctl(input logic [3:0] f,
                                      input logic [4:0] n,
                                      input logic [2:0] fl);
    logic [1:0] u;
    u = fl[2] ? fbox_pkg::UNIT_DEC : fbox_pkg::UNIT_BIN;
    return {fl[0], 11'h000, f, 4'h0, fl[1], 1'b0, u, 3'h0, n};
  endfunction

  function automatic logic [31:0] ar(input logic [4:0] n,
                                     input logic [2:0] fl);
    return ctl(fbox_pkg::FN_ARITH, n, fl);
  endfunction

  task automatic op(input logic [23:0] x, input logic [23:0] y,
                    input logic [31:0] c, input logic [23:0] em,
                    input logic [3:0] eb, input logic [3:0] bm);
    logic [31:0] d;
    wr(fbox_pkg::OFS_X, {8'h00, x});
    wr(fbox_pkg::OFS_Y, {8'h00, y});
    wr(fbox_pkg::OFS_CTRL, c);
    rd(fbox_pkg::OFS_RESULT, d);
    chk(d, {8'h00, em});
    chk(main_exchange, em);
    chk(binary_conditions_word & bm, eb);
    rd(fbox_pkg::OFS_BINARY_CONDITIONS_WORD, d);
    chk(d & {28'h0, bm}, {28'h0, eb});
    load <= 1'b1;
    @(posedge aclk);
    load <= 1'b0;
    @(posedge aclk);
    chk(dest, em);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    chk(binary_conditions_word, 4'h0);
    rd(fbox_pkg::OFS_CTRL, d);
    chk(d, fbox_pkg::CTRL_RESET);
  endtask

  task automatic t_logic;
    logic [23:0] e [1:7];
    e = '{24'hA5, 24'h3C, 24'h42, 24'h99, 24'hDB, 24'h5A, 24'hC3};
    for (int f = 1; f < 8; f++) begin
      op(24'hABCD5A, 24'h1234C3, ctl(4'(f), 5'h8, 3'h0),
         e[f], 4'h8, 4'h8);
    end
    op(24'hABCD5A, 24'h1234C3, ctl(fbox_pkg::FN_INV_X, 5'h18, 3'h0),
       24'h5432A5, 4'h8, 4'h8);
    op(24'hABCD5A, 24'h1234C3, ctl(fbox_pkg::FN_AND, 5'h18, 3'h2),
       24'h0, 4'h8, 4'h8);
    op(24'hABCD5A, 24'h1234C3, ctl(fbox_pkg::FN_XOR, 5'h18, 3'h2),
       24'h0, 4'h8, 4'h8);
  endtask

  task automatic t_arith;
    op(24'h8, 24'h9, ar(5'h4, 3'h0), 24'h1, 4'hB, 4'hF);
    op(24'h5, 24'h3, ar(5'h0, 3'h1), 24'h0, 4'hD, 4'hF);
    op(24'h10, 24'h3, ar(5'h8, 3'h3), 24'hC, 4'hC, 4'hF);
    op(24'h99, 24'h1, ar(5'h8, 3'h0), 24'h9A, 4'h8, 4'hF);
  endtask

  task automatic t_borrow;
    op(24'h100000, 24'h1, ar(5'h4, 3'h2), 24'hF, 4'h0, 4'h2);
    op(24'h5, 24'h100000, ar(5'h4, 3'h2), 24'h5, 4'h2, 4'h2);
    op(24'h7, 24'h7, ar(5'h8, 3'h3), 24'hFF, 4'h2, 4'h2);
    op(24'h7, 24'h7, ar(5'h8, 3'h2), 24'h0, 4'h0, 4'h2);
  endtask

  task automatic t_dec;
    op(24'h7, 24'h8, ar(5'h8, 3'h4), 24'h15, 4'h2, 4'hF);
    op(24'h9, 24'h9, ar(5'h8, 3'h4), 24'h18, 4'h8, 4'hF);
    op(24'h99, 24'h1, ar(5'h8, 3'h4), 24'h0, 4'h1, 4'hF);
    op(24'h17, 24'h9, ar(5'h8, 3'h6), 24'h8, 4'h8, 4'hF);
    op(24'h5, 24'h7, ar(5'h8, 3'h6), 24'h98, 4'h3, 4'hF);
  endtask

  task automatic t_cfm;
    logic [31:0] d;
    logic [1:0]  code [6];
    logic        e [6];
    code = '{2'h0, 2'h1, 2'h0, 2'h3, 2'h0, 2'h2};
    e = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    op(24'h5, 24'h7, ar(5'h8, 3'h2), 24'hFE, 4'hB, 4'hF);
    for (int i = 0; i < 6; i++) begin
      wr(fbox_pkg::OFS_CFM, {30'h0, code[i]});
      rd(fbox_pkg::OFS_BINARY_CONDITIONS_WORD, d);
      chk(d[2], e[i]);
    end
    rd(fbox_pkg::OFS_CTRL, d);
    chk(d[31], 1'b1);
  endtask

  task automatic t_bus;
    logic [31:0] d;
    wr(fbox_pkg::OFS_BINARY_CONDITIONS_WORD, 32'h0);
    chk(resp, fbox_pkg::RESP_OKAY);
    rd(fbox_pkg::OFS_BINARY_CONDITIONS_WORD, d);
    chk(d, 32'hF);
    rd(8'h20, d);
    chk(resp, fbox_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h20, 32'h1);
    chk(resp, fbox_pkg::RESP_SLVERR);
  endtask

  initial begin
    aresetn = 1'b0;
    load = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    awprot = 3'h0;
    arprot = 3'h0;
    fail_count = 0;
    n_tests = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_logic;
    t_arith;
    t_borrow;
    t_dec;
    t_cfm;
    t_bus;
    end_sim;
  end

endmodule // tb

`default_nettype wire
